// File: spic_ctrl.sv
// spic_ctrl: host controller for a word-wide sector-programmed flash
// assumes an Avalon-MM master with waitrequest and the flash on its pins
//
// Behaviour
// - sector address held on every load strobe
// - next word load within 150 us
// - protected program loads all 128 words
// - same page address after protection code
// - judge only successive toggle reads
// - poll reads keep one address
// - command addresses on low fifteen lines
//
// The Avalon-MM slave port and the address map are this design's own decisions.
module spic_ctrl #(
    parameter int unsigned  TWC_CYC     = spic_pkg::TWC_CYC_DOC,
    parameter int unsigned  WLC_CYC     = spic_pkg::WLC_CYC_DOC,
    parameter logic [14:0]  UNLOCK_A1   = 15'h0001,
    parameter logic [14:0]  UNLOCK_A2   = 15'h0002,
    parameter logic [15:0]  UNLOCK_D1   = 16'h00A1,
    parameter logic [15:0]  UNLOCK_D2   = 16'h00A2,
    parameter logic [15:0]  CODE_PROT   = 16'h00C1,
    parameter logic [15:0]  CODE_UNPROT = 16'h00C2,
    parameter logic [15:0]  CODE_ID_IN  = 16'h00C3,
    parameter logic [15:0]  CODE_ID_OUT = 16'h00C4
) (
    // clock and reset
    input  wire logic                  core_clk_in,
    input  wire logic                  srst_in,
    // avalon-mm slave
    input  wire logic [4:0]            avs_address_in,
    input  wire logic                  avs_read_in,
    input  wire logic                  avs_write_in,
    input  wire logic [31:0]           avs_writedata_in,
    output logic      [31:0]           avs_readdata_out,
    output logic                       avs_waitrequest_out,
    // interrupt
    output logic                       irq_out,
    // flash pins
    input  wire logic [15:0]           flash_data_in,
    output spic_pkg::spic_pins_t       flash_pins_out
);
    import spic_pkg::*;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        F_IDLE  = 4'h0, F_PFX   = 4'h1, F_PFXW  = 4'h2, F_LOAD  = 4'h3,
        F_LOADW = 4'h4, F_POLL  = 4'h5, F_POLLW = 4'h6, F_READ  = 4'h7,
        F_READW = 4'h8, F_FIN   = 4'h9
    } spic_fsm_t;

    typedef struct packed {
        spic_fsm_t         fsm;
        spic_cmd_t         cmd;
        logic [1:0]        step;
        logic [7:0]        idx;
        logic [127:0][15:0] wbuf;
        logic [6:0]        wptr;
        logic [8:0]        sector;
        logic [15:0]       raddr;
        logic [15:0]       rdata;
        logic [15:0]       paddr;
        logic              first;
        logic [1:0]        prev_tog;
        logic              tout;
        logic [19:0]       tmr;
        logic [12:0]       gap;
        logic              prot;
        logic              idm;
        logic [2:0]        irq_stat;
        logic [2:0]        irq_mask;
        logic              irq;
        logic              waitreq;
        logic [31:0]       avs_rdata;
        logic              start;
        spic_req_t         req;
    } spic_st_t;

    spic_st_t   st, next_st;
    logic [15:0] sync_data;
    logic        cyc_done;
    logic [15:0] cyc_rdata;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic spic_req_t wr_req(input logic [15:0] a,
                                         input logic [15:0] d);
        spic_req_t r;
        r.wr = 1'b1;
        r.addr = a;
        r.data = d;
        return r;
    endfunction

    // unlock pair then the command code, all on the low address lines
    function automatic spic_req_t pfx_req(input logic [1:0] step,
                                          input spic_cmd_t c);
        logic [15:0] code;
        case (c)
            CMD_PPROG, CMD_PROT_ON: code = CODE_PROT;
            CMD_PROT_OFF:           code = CODE_UNPROT;
            CMD_ID_IN:              code = CODE_ID_IN;
            default:                code = CODE_ID_OUT;
        endcase
        case (step)
            2'h0:    return wr_req({1'b0, UNLOCK_A1}, UNLOCK_D1);
            2'h1:    return wr_req({1'b0, UNLOCK_A2}, UNLOCK_D2);
            default: return wr_req({1'b0, UNLOCK_A1}, code);
        endcase
    endfunction

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        logic       wr_acc;
        logic       busy;
        logic [2:0] set_bits;
        logic [2:0] clr_bits;
        logic       same;
        wr_acc = avs_write_in && !st.waitreq;
        busy = (st.fsm != F_IDLE);
        set_bits = 3'h0;
        clr_bits = 3'h0;
        same = (cyc_rdata[6] == st.prev_tog[0]) &&
               (cyc_rdata[14] == st.prev_tog[1]);
        next_st = st;
        next_st.start = 1'b0;

        // bus slave: one wait cycle, then a single acknowledge cycle
        next_st.waitreq = !((avs_read_in || avs_write_in) && st.waitreq);
        if (avs_read_in && st.waitreq) begin
            case (avs_address_in)
                REG_CTRL:     next_st.avs_rdata = {29'h0, st.cmd};
                REG_SECTOR:   next_st.avs_rdata = {23'h0, st.sector};
                REG_RADDR:    next_st.avs_rdata = {16'h0, st.raddr};
                REG_WDATA:    next_st.avs_rdata = {25'h0, st.wptr};
                REG_RDATA:    next_st.avs_rdata = {16'h0, st.rdata};
                REG_STATUS:   next_st.avs_rdata = {29'h0, st.idm,
                                                   st.prot, busy};
                REG_IRQ_STAT: next_st.avs_rdata = {29'h0, st.irq_stat};
                REG_IRQ_MASK: next_st.avs_rdata = {29'h0, st.irq_mask};
                default:      next_st.avs_rdata = 32'h0000_0000;
            endcase
        end
        if (wr_acc) begin
            case (avs_address_in)
                REG_SECTOR:   if (!busy) next_st.sector = avs_writedata_in[8:0];
                REG_RADDR:    next_st.raddr = avs_writedata_in[15:0];
                REG_IRQ_STAT: clr_bits = avs_writedata_in[2:0];
                REG_IRQ_MASK: next_st.irq_mask = avs_writedata_in[2:0];
                REG_WDATA: begin
                    if (busy) begin
                        set_bits[IRQ_REFUSED] = 1'b1;
                    end else begin
                        next_st.wbuf[st.wptr] = avs_writedata_in[15:0];
                        next_st.wptr = st.wptr + 7'h01;
                    end
                end
                REG_CTRL: begin
                    if (busy || avs_writedata_in[2:0] == CMD_NONE) begin
                        set_bits[IRQ_REFUSED] = 1'b1;
                    end else begin
                        next_st.cmd = spic_cmd_t'(avs_writedata_in[2:0]);
                        next_st.step = 2'h0;
                        next_st.idx = 8'h00;
                        next_st.tout = 1'b0;
                        // a protected part only takes the coded sequence
                        if (next_st.cmd == CMD_PROG && st.prot) begin
                            next_st.cmd = CMD_PPROG;
                        end
                        case (next_st.cmd)
                            CMD_READ: next_st.fsm = F_READ;
                            CMD_PROG: next_st.fsm = F_LOAD;
                            default:  next_st.fsm = F_PFX;
                        endcase
                    end
                end
                default: ;
            endcase
        end

        // sequencer
        if (st.tmr != 20'hFFFFF) begin
            next_st.tmr = st.tmr + 20'h00001;
        end
        next_st.gap = (st.fsm == F_LOAD) ? 13'h0000 : st.gap + 13'h0001;
        case (st.fsm)
            F_IDLE: ;
            F_PFX: begin
                next_st.req = pfx_req(st.step, st.cmd);
                next_st.start = 1'b1;
                next_st.fsm = F_PFXW;
            end
            F_PFXW: if (cyc_done) begin
                next_st.step = st.step + 2'h1;
                next_st.fsm = F_PFX;
                if (st.step == 2'h2) begin
                    next_st.first = 1'b1;
                    next_st.tmr = 20'h00000;
                    next_st.paddr = {1'b0, UNLOCK_A1};
                    case (st.cmd)
                        CMD_PPROG:   next_st.fsm = F_LOAD;
                        CMD_PROT_ON, CMD_PROT_OFF:
                                     next_st.fsm = F_POLL;
                        default:     next_st.fsm = F_FIN;
                    endcase
                end
            end
            F_LOAD: begin
                // whole sector every time so no word is left undefined
                next_st.req = wr_req({st.sector, st.idx[6:0]},
                                     st.wbuf[st.idx[6:0]]);
                next_st.start = 1'b1;
                next_st.fsm = F_LOADW;
            end
            F_LOADW: if (cyc_done) begin
                next_st.idx = st.idx + 8'h01;
                next_st.fsm = F_LOAD;
                if (st.idx == LAST_IDX) begin
                    next_st.fsm = F_POLL;
                    next_st.first = 1'b1;
                    next_st.tmr = 20'h00000;
                    next_st.paddr = {st.sector, 7'h00};
                end
            end
            F_POLL: begin
                next_st.req = '{wr: 1'b0, addr: st.paddr,
                                data: 16'h0000};
                next_st.start = 1'b1;
                next_st.fsm = F_POLLW;
            end
            F_POLLW: if (cyc_done) begin
                next_st.prev_tog = {cyc_rdata[14], cyc_rdata[6]};
                next_st.first = 1'b0;
                next_st.fsm = F_POLL;
                if (!st.first && same) begin
                    next_st.fsm = F_FIN;
                end else if (st.tmr >= 20'(TWC_CYC)) begin
                    next_st.tout = 1'b1;
                    next_st.fsm = F_FIN;
                end
            end
            F_READ: begin
                next_st.req = '{wr: 1'b0, addr: st.raddr, data: 16'h0000};
                next_st.start = 1'b1;
                next_st.fsm = F_READW;
            end
            F_READW: if (cyc_done) begin
                next_st.rdata = cyc_rdata;
                next_st.fsm = F_FIN;
            end
            F_FIN: begin
                set_bits[IRQ_DONE] = !st.tout;
                set_bits[IRQ_TIMEOUT] = st.tout;
                if (!st.tout) begin
                    case (st.cmd)
                        CMD_PPROG, CMD_PROT_ON: next_st.prot = 1'b1;
                        CMD_PROT_OFF:           next_st.prot = 1'b0;
                        CMD_ID_IN:              next_st.idm = 1'b1;
                        CMD_ID_OUT:             next_st.idm = 1'b0;
                        default: ;
                    endcase
                end
                if (st.cmd == CMD_PROG || st.cmd == CMD_PPROG) begin
                    next_st.wptr = 7'h00;
                end
                next_st.fsm = F_IDLE;
            end
            default: next_st.fsm = F_IDLE;
        endcase

        // a new event wins over a clear in the same cycle
        next_st.irq_stat = (st.irq_stat & ~clr_bits) | set_bits;
        next_st.irq = |(next_st.irq_stat & next_st.irq_mask);
    end

    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            st <= '{fsm: F_IDLE, cmd: CMD_NONE, waitreq: 1'b1,
                    default: '0};
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------
    // pin side
    // ------------------------------------------------------------------
    spic_sync u_sync (
        .core_clk_in (core_clk_in),
        .srst_in     (srst_in),
        .pin_in      (flash_data_in),
        .value_out   (sync_data)
    );

    spic_cycle u_cycle (
        .core_clk_in (core_clk_in),
        .srst_in     (srst_in),
        .start_in    (st.start),
        .req_in      (st.req),
        .rd_data_in  (sync_data),
        .done_out    (cyc_done),
        .rdata_out   (cyc_rdata),
        .pins_out    (flash_pins_out)
    );

    assign avs_readdata_out = st.avs_rdata;
    assign avs_waitrequest_out = st.waitreq;
    assign irq_out = st.irq;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (srst_in);

    a_oe_while_write: assert property (
        (!flash_pins_out.we_n && !flash_pins_out.ce_n)
            |-> flash_pins_out.oe_n)
        else $error("output enable low during a write strobe");
    a_sector_on_load: assert property (
        ($fell(flash_pins_out.we_n) && st.fsm == F_LOADW)
            |-> flash_pins_out.addr[15:7] == st.sector)
        else $error("load strobe outside the target sector");
    a_load_gap: assert property (
        (st.fsm == F_LOADW) |-> (st.gap < 13'(WLC_CYC)))
        else $error("word load spacing too long");
    a_full_sector: assert property (
        (st.fsm == F_LOADW && cyc_done)
            |=> ((st.fsm == F_POLL) == ($past(st.idx) == LAST_IDX)))
        else $error("sector load ended early or ran over");
    a_poll_same_addr: assert property (
        (st.fsm == F_POLLW && !flash_pins_out.oe_n)
            |-> flash_pins_out.addr == st.paddr)
        else $error("poll address moved");
    a_first_poll_kept: assert property (
        (st.fsm == F_POLLW && cyc_done && st.first
            && st.tmr < 20'(TWC_CYC)) |=> st.fsm == F_POLL)
        else $error("completion judged from a single read");
    a_poll_timeout: assert property (
        (st.fsm == F_POLLW && cyc_done && st.tmr >= 20'(TWC_CYC))
            |=> st.fsm == F_FIN ##1 st.irq_stat[IRQ_DONE]
                || st.irq_stat[IRQ_TIMEOUT])
        else $error("poll ran past the program cycle bound");
    a_cmd_low_lines: assert property (
        (st.fsm == F_PFXW && !flash_pins_out.we_n)
            |-> flash_pins_out.addr[15] == 1'b0)
        else $error("command address uses the top line");
    a_bus_ack: assert property (
        ((avs_read_in || avs_write_in) && st.waitreq)
            |=> !st.waitreq ##1 st.waitreq)
        else $error("bus request not answered in one cycle");

    c_prog_done: cover property (
        st.fsm == F_FIN && st.cmd == CMD_PPROG && !st.tout);
    c_timeout: cover property (st.fsm == F_FIN && st.tout);
    c_id_entry: cover property (st.fsm == F_FIN && st.cmd == CMD_ID_IN);
    c_read: cover property (st.fsm == F_READW && cyc_done);
endmodule

// File: spic_pkg.sv
// spic_pkg: shared constants, types and timing for the flash host controller
// assumes a 50 MHz core clock; all pin timing is derived from it here
package spic_pkg;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_NS    = 20;
    localparam int T_WP_NS   = 70;
    localparam int T_WPH_NS  = 100;
    localparam int T_ACC_NS  = 150;
    localparam int T_OEHP_NS = 150;
    localparam int T_WC_MS   = 10;
    localparam int T_WLC_US  = 150;
    localparam int SYNC_LAT  = 4;

    function automatic int ceil_cyc(input int ns);
        return (ns + CLK_NS - 1) / CLK_NS;
    endfunction

    localparam logic [3:0] WP_CNT   = 4'(ceil_cyc(T_WP_NS) - 1);
    localparam logic [3:0] WPH_CNT  = 4'(ceil_cyc(T_WPH_NS) - 1);
    localparam logic [3:0] RD_CNT   = 4'(ceil_cyc(T_ACC_NS) + SYNC_LAT - 1);
    localparam logic [3:0] OEHP_CNT = 4'(ceil_cyc(T_OEHP_NS) - 1);
    localparam int TWC_CYC_DOC = T_WC_MS * 1000000 / CLK_NS;
    localparam int WLC_CYC_DOC = T_WLC_US * 1000 / CLK_NS;

    // ------------------------------------------------------------------
    // register map (byte offsets) and layout
    // ------------------------------------------------------------------
    localparam logic [4:0] REG_CTRL     = 5'h00;
    localparam logic [4:0] REG_SECTOR   = 5'h04;
    localparam logic [4:0] REG_RADDR    = 5'h08;
    localparam logic [4:0] REG_WDATA    = 5'h0C;
    localparam logic [4:0] REG_RDATA    = 5'h10;
    localparam logic [4:0] REG_STATUS   = 5'h14;
    localparam logic [4:0] REG_IRQ_STAT = 5'h18;
    localparam logic [4:0] REG_IRQ_MASK = 5'h1C;
    localparam int IRQ_DONE    = 0;
    localparam int IRQ_TIMEOUT = 1;
    localparam int IRQ_REFUSED = 2;
    localparam logic [7:0] LAST_IDX = 8'h7F;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        CMD_NONE = 3'h0, CMD_PROG = 3'h1, CMD_PPROG = 3'h2,
        CMD_PROT_ON = 3'h3, CMD_PROT_OFF = 3'h4, CMD_ID_IN = 3'h5,
        CMD_ID_OUT = 3'h6, CMD_READ = 3'h7
    } spic_cmd_t;

    typedef struct packed {
        logic        wr;
        logic [15:0] addr;
        logic [15:0] data;
    } spic_req_t;

    typedef struct packed {
        logic        ce_n;
        logic        oe_n;
        logic        we_n;
        logic        data_oe_n;
        logic [15:0] addr;
        logic [15:0] data;
    } spic_pins_t;

    localparam spic_pins_t PINS_IDLE = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
        data_oe_n: 1'b1, addr: 16'h0000, data: 16'h0000};

endpackage

// File: spic_sync.sv
// spic_sync: three-stage input synchroniser for the flash data pins
// assumes the pins are asynchronous; a change is taken once stages agree
module spic_sync (
    // clock and reset
    input  wire logic        core_clk_in,
    input  wire logic        srst_in,
    // pins and synchronised value
    input  wire logic [15:0] pin_in,
    output logic      [15:0] value_out
);
    import spic_pkg::*;

    typedef struct packed {
        logic [15:0] s1;
        logic [15:0] s2;
        logic [15:0] s3;
        logic [15:0] q;
    } spic_sync_st_t;

    spic_sync_st_t st, next_st;

    always_comb begin
        next_st = st;
        next_st.s1 = pin_in;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        // per-bit agreement keeps one metastable stage from leaking
        next_st.q = (st.s2 & st.s3) | (st.q & (st.s2 ^ st.s3));
    end

    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign value_out = st.q;
endmodule

// File: spic_cycle.sv
// spic_cycle: one strobed write or read cycle on the flash pins
// assumes read data arrives already synchronised; start only when idle
module spic_cycle (
    // clock and reset
    input  wire logic                 core_clk_in,
    input  wire logic                 srst_in,
    // request and answer
    input  wire logic                 start_in,
    input  wire spic_pkg::spic_req_t  req_in,
    input  wire logic [15:0]          rd_data_in,
    output logic                      done_out,
    output logic      [15:0]          rdata_out,
    // flash pins
    output spic_pkg::spic_pins_t      pins_out
);
    import spic_pkg::*;

    typedef enum logic [1:0] {
        CY_IDLE = 2'b00, CY_WLOW = 2'b01, CY_RLOW = 2'b10, CY_GAP = 2'b11
    } spic_cy_t;

    typedef struct packed {
        spic_cy_t    ph;
        logic [3:0]  cnt;
        spic_pins_t  pins;
        logic        done;
        logic [15:0] rdata;
    } spic_cyc_st_t;

    spic_cyc_st_t st, next_st;

    always_comb begin
        next_st = st;
        next_st.done = 1'b0;
        case (st.ph)
            CY_IDLE: if (start_in) begin
                next_st.pins.addr = req_in.addr;
                next_st.pins.data = req_in.data;
                next_st.pins.ce_n = 1'b0;
                if (req_in.wr) begin
                    next_st.pins.we_n = 1'b0;
                    next_st.pins.data_oe_n = 1'b0;
                    next_st.ph = CY_WLOW;
                    next_st.cnt = WP_CNT;
                end else begin
                    next_st.pins.oe_n = 1'b0;
                    next_st.ph = CY_RLOW;
                    next_st.cnt = RD_CNT;
                end
            end
            CY_WLOW, CY_RLOW: if (st.cnt == 4'h0) begin
                if (st.ph == CY_RLOW) begin
                    next_st.rdata = rd_data_in;
                end
                // address and data stay put through the high time
                next_st.pins.we_n = 1'b1;
                next_st.pins.oe_n = 1'b1;
                next_st.pins.ce_n = 1'b1;
                next_st.ph = CY_GAP;
                next_st.cnt = (st.ph == CY_RLOW) ? OEHP_CNT : WPH_CNT;
            end else begin
                next_st.cnt = st.cnt - 4'h1;
            end
            CY_GAP: if (st.cnt == 4'h0) begin
                next_st.pins.data_oe_n = 1'b1;
                next_st.done = 1'b1;
                next_st.ph = CY_IDLE;
            end else begin
                next_st.cnt = st.cnt - 4'h1;
            end
            default: next_st.ph = CY_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            st <= '{ph: CY_IDLE, pins: PINS_IDLE, default: '0};
        end else begin
            st <= next_st;
        end
    end

    assign done_out = st.done;
    assign rdata_out = st.rdata;
    assign pins_out = st.pins;
endmodule

// File: spic_flash_model.sv
// spic_flash_model: behavioural word-wide sector flash for the bench
// assumes pins are sampled on the bench clock; ids are arbitrary values
module spic_flash_model #(
    parameter logic [15:0] MAKER_ID = 16'h00A5, // arbitrary value
    parameter logic [15:0] PART_ID  = 16'h005A  // arbitrary value
) (
    // bench clock and speed
    input  wire logic                 clk_in,
    input  wire logic                 slow_in,
    // flash pins
    input  wire spic_pkg::spic_pins_t pins_in,
    output logic      [15:0]          data_out
);
    import spic_pkg::*;
    logic [31:0] p1 = '0;
    logic [31:0] p2 = '0;
    logic [15:0] last = '0;
    logic [15:0] v;
    logic        ws_q = 0, rs_q = 0, tgl = 0, prot = 0, pend = 0;
    logic        idm = 0; // comes up in normal operation
    int          busy = 0, n_loads = 0;
    wire         ws = !pins_in.ce_n && !pins_in.we_n;
    wire         rs = !pins_in.ce_n && !pins_in.oe_n;
    always_comb begin
        if (busy > 0)
            v = {~p1[15], tgl, 6'h00, ~p1[7], tgl, 6'h00};
        else if (idm && pins_in.addr[15:1] == 15'h0000)
            v = pins_in.addr[0] ? PART_ID : MAKER_ID;
        else
            v = ~pins_in.addr; // no array: unloaded words arbitrary
    end
    // released bus shows the inverse, never a stale value
    assign data_out = rs ? v : ~last;
    always @(posedge clk_in) begin
        ws_q <= ws;
        rs_q <= rs;
        if (rs)
            last <= v;
        if (rs && !rs_q && busy > 0)
            tgl <= ~tgl;
        if (busy == 1)
            prot <= pend;
        if (busy > 0)
            busy <= busy - 1;
        if (ws_q && !ws) begin
            p2 <= p1;
            p1 <= {pins_in.addr, pins_in.data};
            n_loads <= n_loads + 1;
            busy <= slow_in ? 400 : 40;
            if (p2[30:0] == 31'h100A1 && p1[30:0] == 31'h200A2
                && pins_in.addr[14:0] == 15'h0001) begin
                case (pins_in.data)
                    16'h00C1: pend <= 1'b1;
                    16'h00C2: pend <= 1'b0;
                    16'h00C3: idm <= 1'b1;
                    16'h00C4: idm <= 1'b0;
                    default: ;
                endcase
                // id commands start no internal write period
                if (pins_in.data == 16'h00C3 || pins_in.data == 16'h00C4)
                    busy <= 0;
            end
        end
    end
endmodule

// File: spic_ctrl_test.sv
// spic_ctrl_test: self-checking bench for the flash host controller
// assumes the behavioural flash model stands on the pins
module spic_ctrl_test;
    timeunit 1ns;
    timeprecision 1ps;
    import spic_pkg::*;
    logic        clk = 0, rst = 1, rd = 0, wr = 0, slow = 0, wq, irq;
    logic [4:0]  adr = '0;
    logic [31:0] wd = '0, rv, rdat;
    logic [15:0] md;
    spic_pins_t  pins;
    int          n_mismatch = 0, checks = 0, n;
    always #10 clk = ~clk;
    spic_ctrl #(.TWC_CYC(200)) i_spic_ctrl (.core_clk_in(clk), .srst_in(rst),
        .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
        .avs_writedata_in(wd), .avs_readdata_out(rdat),
        .avs_waitrequest_out(wq), .irq_out(irq),
        .flash_data_in(pins.data_oe_n ? md : pins.data),
        .flash_pins_out(pins));
    spic_flash_model i_spic_flash_model (.clk_in(clk), .slow_in(slow),
        .pins_in(pins), .data_out(md));
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("BAD %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic bus(input logic w, input logic [4:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        adr <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        do @(posedge clk); while (wq !== 1'b0);
        rv = rdat;
        wr <= 0;
        rd <= 0;
    endtask
    // no limit of its own: the watchdog ends a wait that never returns
    task automatic wait_irq;
        while (irq !== 1'b1) @(posedge clk);
    endtask
    task automatic cmd(input logic [31:0] c);
        bus(1, REG_CTRL, c);
        wait_irq;
    endtask
    task automatic ack(input logic [31:0] e);
        bus(0, REG_IRQ_STAT, 0);
        chk(rv, e);
        bus(1, REG_IRQ_STAT, e);
        repeat (2) @(negedge clk);
        chk(irq, 0);
    endtask
    task automatic rd_at(input logic [31:0] a, input logic [31:0] e);
        bus(1, REG_RADDR, a);
        cmd(7);
        ack(1);
        bus(0, REG_RDATA, 0);
        chk(rv, e);
    endtask
    task automatic t_prot;
        bus(1, REG_IRQ_MASK, 7);
        cmd(3);
        ack(1);
        bus(0, REG_STATUS, 0);
        chk(rv, 2);
        chk(i_spic_flash_model.prot, 1);
        cmd(4);
        ack(1);
        bus(0, REG_STATUS, 0);
        chk(rv, 0);
        chk(i_spic_flash_model.prot, 0);
        $display("t_prot done");
    endtask
    task automatic t_prog;
        bus(1, REG_SECTOR, 5);
        for (int i = 0; i < 128; i++) bus(1, REG_WDATA, i);
        // plain program, then the coded sequence on the kept buffer
        for (int c = 1; c < 3; c++) begin
            n = i_spic_flash_model.n_loads;
            cmd(c);
            ack(1);
            chk(i_spic_flash_model.n_loads - n, 125 + 3 * c);
            chk(i_spic_flash_model.p1, 32'h02FF007F);
        end
        bus(0, REG_STATUS, 0);
        chk(rv, 2);
        cmd(4);
        ack(1);
        $display("t_prog done");
    endtask
    task automatic t_id;
        cmd(5);
        ack(1);
        rd_at(0, 32'h00A5);
        rd_at(1, 32'h005A);
        cmd(6);
        ack(1);
        rd_at(0, 32'hFFFF);
        $display("t_id done");
    endtask
    task automatic t_slow;
        bus(1, REG_IRQ_MASK, 3);
        slow <= 1;
        bus(1, REG_CTRL, 3);
        bus(1, REG_CTRL, 1);
        repeat (2) @(negedge clk);
        chk(irq, 0);
        ack(4);
        wait_irq;
        ack(2);
        bus(0, REG_STATUS, 0);
        chk(rv, 0);
        slow <= 0;
        repeat (500) @(posedge clk);
        $display("t_slow done");
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst <= 0;
        t_prot;
        t_prog;
        t_id;
        t_slow;
        tally_and_finish;
    end
    initial begin
        repeat (60000) @(posedge clk);
        n_mismatch++;
        tally_and_finish;
    end
endmodule
